// ==== lbcc_pkg.sv ====
// lbcc_pkg: constants, states and carrier types for the local bus control.
// assumes a single 25 MHz clock domain and active-low bus strobes.
package lbcc_pkg;

    // ------------------------------------------------------------------
    // address map defaults
    // ------------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam logic [19:0] UPPER_DEF_LO = 20'hffc00; // default upper window
    localparam logic [19:0] UPPER_DEF_HI = 20'hfffff;
    localparam logic [19:0] LOWER_DEF_LO = 20'h00000;
    localparam logic [19:0] LOWER_DEF_HI = 20'h00000;

    // ------------------------------------------------------------------
    // queue status codes {high, low}
    // ------------------------------------------------------------------
    localparam logic [1:0] QS_NONE = 2'h0;
    localparam logic [1:0] QS_FIRST = 2'h1;
    localparam logic [1:0] QS_NEXT = 2'h3;
    localparam logic [1:0] QS_EMPTY = 2'h2;

    // byte lane codes {a0, high_byte_enable}
    localparam logic [1:0] LANE_WORD = 2'h0;
    localparam logic [1:0] LANE_EVEN = 2'h1;
    localparam logic [1:0] LANE_ODD = 2'h2;
    localparam logic [1:0] LANE_REFRESH = 2'h3;

    // ------------------------------------------------------------------
    // bus cycle states, gray coded along idle-addr-data-end
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LBCC_IDLE = 3'h0,
        LBCC_ADDR = 3'h1,
        LBCC_DATA = 3'h3,
        LBCC_DONE = 3'h2,
        LBCC_HELD = 3'h6
    } lbcc_state_t;

    // request from the core for one bus cycle
    typedef struct packed {
        logic [19:0] addr;
        logic is_write;
        logic is_io;
        logic is_refresh;
        logic byte_only;  // single byte transfer
        logic locked;
    } lbcc_req_t;

    // chip select programming
    typedef struct packed {
        logic upper_prog;
        logic [19:0] upper_lo;
        logic [19:0] upper_hi;
        logic upper_no_ready;
        logic lower_prog;
        logic [19:0] lower_lo;
        logic [19:0] lower_hi;
        logic lower_no_ready;
    } lbcc_cs_cfg_t;

endpackage : lbcc_pkg

// ==== lbcc_local_bus.sv ====
// lbcc_local_bus: bus cycle sequencer, strobes, ready, hold, chip selects.
// assumes a core that issues one request pulse and waits for done.
//
// How it works
// R1 - queue mode shows queue activity as 00 none, 01 first, 11 next, 10 flush
// R2 - read strobe pin low at reset release selects queue status mode
// R3 - in queue mode write pin carries high bit, latch pin the low bit
// R4 - write strobe active while write data sits on the bus
// R5 - async ready is synchronised before use, fall edge timing folded in
// R6 - outside a window that waives ready, a cycle ends only on async or sync ready
// R7 - ready ignored when the selecting window is programmed to ignore it
// R8 - transceiver enable active only during data phase
// R9 - transceiver direction high for writes, low for reads
// R10 - no hold grant while a locked cycle runs
// R11 - lock pin is an input during reset; outputs not enabled then
// R12 - hold granted at instruction boundary outside lock
// R13 - grant raises hold_grant and floats data and control
// R14 - after reset upper select covers the default top window
// R15 - programmed upper select covers memory and io in its limits
// R16 - lower select off after reset, memory only pin_float_test_mode programmed
// R17 - select pins sampled at reset release choose pin-float test mode; the code only sets test_mode_reg, pins stay driven
// R18 - narrow variant drives refresh indicator low on refresh cycles
// R19 - address latch strobe pulses during the address phase
// R20 - wide variant encodes lanes as a0 and high byte enable
// R21 - read strobe active while the device should drive data
module lbcc_local_bus
    import lbcc_pkg::*;
#(
    parameter bit NARROW_BUS = 1'b0
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire lbcc_req_t req,
    input wire logic boundary,
    input wire logic [1:0] queue_op,
    input wire lbcc_cs_cfg_t cs_cfg,
    input wire logic async_ready_in,
    input wire logic sync_ready_in,
    input wire logic hold_req,
    input wire logic read_strobe_in,
    input wire logic upper_select_in,
    input wire logic lower_select_in,
    output logic done_reg,
    output logic queue_mode_reg,
    output logic test_mode_reg,
    output logic [19:0] addr_reg,
    output logic read_strobe_n_reg,
    output logic write_strobe_n_reg,
    output logic addr_latch_reg,
    output logic transceiver_enable_n_reg,
    output logic transceiver_direction_reg,
    output logic lock_n_reg,
    output logic lock_oe_reg,
    output logic ctrl_oe_reg,
    output logic hold_grant_reg,
    output logic upper_memory_select_n_reg,
    output logic lower_memory_select_n_reg,
    output logic high_byte_enable_n_reg,
    output logic refresh_indicator_n_reg
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic in_range(input logic [19:0] a,
                                      input logic [19:0] lo,
                                      input logic [19:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    lbcc_state_t state_reg;
    lbcc_req_t cur_reg;
    logic async_ready_in_meta_reg;
    logic async_ready_in_sync_reg;
    logic strap_done_reg;
    logic upper_hit;
    logic lower_hit;
    logic ready_ok;
    logic [1:0] lane;
    logic grant_now;
    logic float_next;

    // ------------------------------------------------------------------
    // decode of the held request
    // ------------------------------------------------------------------
    always_comb
    begin
        if (cs_cfg.upper_prog)
        begin
            upper_hit = !cur_reg.is_refresh &&
                in_range(cur_reg.addr, cs_cfg.upper_lo, cs_cfg.upper_hi); // R15
        end
        else
        begin
            upper_hit = !cur_reg.is_io && !cur_reg.is_refresh &&
                in_range(cur_reg.addr, UPPER_DEF_LO, UPPER_DEF_HI); // R14
        end
        lower_hit = cs_cfg.lower_prog && !cur_reg.is_io &&
            !cur_reg.is_refresh &&
            in_range(cur_reg.addr, cs_cfg.lower_lo, cs_cfg.lower_hi); // R16
        // ready from either source, unless the window waives it; the raw
        // async pin is never read here, only its synchronised copy
        ready_ok = async_ready_in_sync_reg || sync_ready_in; // R6
        if ((upper_hit && cs_cfg.upper_no_ready) ||
            (lower_hit && cs_cfg.lower_no_ready))
        begin
            ready_ok = 1'b1; // R7
        end
        if (cur_reg.is_refresh)
        begin
            lane = LANE_REFRESH;
        end
        else if (!cur_reg.byte_only)
        begin
            lane = LANE_WORD;
        end
        else
        begin
            lane = cur_reg.addr[0] ? LANE_ODD : LANE_EVEN;
        end
        // hold is decided here so the pin drivers float on the very edge
        // that raises the grant; a registered view would drive one cycle
        // into the other master's tenure
        grant_now = (state_reg == LBCC_IDLE) && hold_req && boundary &&
            !cur_reg.locked; // R10 R12
        // control stays off the pins before straps are taken and while held
        float_next = !strap_done_reg || (state_reg == LBCC_HELD) ||
            grant_now; // R13
    end

    // ------------------------------------------------------------------
    // async ready synchroniser; sync ready used as sampled
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            async_ready_in_meta_reg <= 1'b0;
            async_ready_in_sync_reg <= 1'b0;
        end
        else
        begin
            // two flops settle a level that may move near the rising edge;
            // the cost is two cycles of extra wait on every async cycle
            async_ready_in_meta_reg <= async_ready_in; // R5
            async_ready_in_sync_reg <= async_ready_in_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // straps caught on the first edge after reset release
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            strap_done_reg <= 1'b0;
            queue_mode_reg <= 1'b0;
            test_mode_reg <= 1'b0;
        end
        else if (!strap_done_reg)
        begin
            // the board must hold the straps through this edge; later
            // changes on the pins are ignored until the next reset
            strap_done_reg <= 1'b1;
            queue_mode_reg <= !read_strobe_in; // R2
            test_mode_reg <= !upper_select_in && !lower_select_in; // R17
        end
    end

    // ------------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= LBCC_IDLE;
            cur_reg <= '0;
            done_reg <= 1'b0;
            hold_grant_reg <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            case (state_reg)
                LBCC_IDLE:
                begin
                    // hold wins only between instructions, never under lock;
                    // a request arriving on the same edge waits for release
                    if (grant_now) // R10 R12
                    begin
                        state_reg <= LBCC_HELD;
                        hold_grant_reg <= 1'b1; // R13
                    end
                    else if (req_valid && strap_done_reg)
                    begin
                        cur_reg <= req;
                        state_reg <= LBCC_ADDR;
                    end
                end
                LBCC_ADDR:
                begin
                    state_reg <= LBCC_DATA;
                end
                LBCC_DATA:
                begin
                    // wait states last as long as no usable ready is seen
                    if (ready_ok) // R6
                    begin
                        state_reg <= LBCC_DONE;
                    end
                end
                LBCC_DONE:
                begin
                    done_reg <= 1'b1;
                    // lock ends with its cycle; the core still shows the
                    // finished request here, so it cannot say what follows
                    cur_reg.locked <= 1'b0;
                    state_reg <= LBCC_IDLE;
                end
                LBCC_HELD:
                begin
                    if (!hold_req)
                    begin
                        hold_grant_reg <= 1'b0;
                        state_reg <= LBCC_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= LBCC_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pin drivers, registered from the present state view of this cycle
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_reg <= '0;
            read_strobe_n_reg <= 1'b1;
            write_strobe_n_reg <= 1'b1;
            addr_latch_reg <= 1'b0;
            transceiver_enable_n_reg <= 1'b1;
            transceiver_direction_reg <= 1'b0;
            lock_n_reg <= 1'b1;
            lock_oe_reg <= 1'b0; // R11
            ctrl_oe_reg <= 1'b0;
            upper_memory_select_n_reg <= 1'b1;
            lower_memory_select_n_reg <= 1'b1;
            high_byte_enable_n_reg <= 1'b1;
            refresh_indicator_n_reg <= 1'b1;
        end
        else
        begin
            // control floats while held, while being granted, before straps
            ctrl_oe_reg <= !float_next; // R13
            lock_oe_reg <= !float_next; // R11
            // the wide bus marks refresh with a0 high beside the byte enable;
            // word and refresh cycles thus never show the raw bit zero
            if (NARROW_BUS)
            begin
                addr_reg <= cur_reg.addr;
            end
            else
            begin
                addr_reg <= {cur_reg.addr[19:1], lane[1]}; // R20
            end
            addr_latch_reg <= queue_mode_reg ? queue_op[0] :
                (state_reg == LBCC_ADDR); // R19 R1 R3
            // refresh runs as a dummy read so the far side can end it with
            // ready; with no strobe a refresh would wait forever
            read_strobe_n_reg <= !((state_reg == LBCC_DATA) &&
                !cur_reg.is_write); // R21
            write_strobe_n_reg <= queue_mode_reg ? queue_op[1] :
                !((state_reg == LBCC_DATA) && cur_reg.is_write); // R4 R1 R3
            transceiver_enable_n_reg <= !((state_reg == LBCC_DATA) &&
                !cur_reg.is_refresh); // R8
            transceiver_direction_reg <= cur_reg.is_write; // R9
            lock_n_reg <= !(cur_reg.locked && state_reg != LBCC_IDLE);
            upper_memory_select_n_reg <= !(upper_hit &&
                (state_reg == LBCC_ADDR || state_reg == LBCC_DATA));
            lower_memory_select_n_reg <= !(lower_hit &&
                (state_reg == LBCC_ADDR || state_reg == LBCC_DATA));
            if (NARROW_BUS)
            begin
                refresh_indicator_n_reg <= !cur_reg.is_refresh; // R18
                high_byte_enable_n_reg <= 1'b1;
            end
            else
            begin
                high_byte_enable_n_reg <= lane[0]; // R20
                refresh_indicator_n_reg <= 1'b1;
            end
        end
    end

endmodule : lbcc_local_bus

// ==== lbcc_local_bus_monitor.sv ====
// lbcc_local_bus_monitor: port checks for the local bus control.
// assumes a bind onto lbcc_local_bus; sees its ports only.
module lbcc_local_bus_monitor
    import lbcc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [1:0] queue_op,
    input wire lbcc_cs_cfg_t cs_cfg,
    input wire logic async_ready_in,
    input wire logic sync_ready_in,
    input wire logic done_reg,
    input wire logic queue_mode_reg,
    input wire logic [19:0] addr_reg,
    input wire logic read_strobe_n_reg,
    input wire logic write_strobe_n_reg,
    input wire logic addr_latch_reg,
    input wire logic transceiver_enable_n_reg,
    input wire logic transceiver_direction_reg,
    input wire logic lock_n_reg,
    input wire logic lock_oe_reg,
    input wire logic ctrl_oe_reg,
    input wire logic hold_grant_reg,
    input wire logic upper_memory_select_n_reg,
    input wire logic lower_memory_select_n_reg
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    logic [3:0] age_reg;
    // cycles since a ready was seen; saturates so it never wraps
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n)
            age_reg <= 4'hf;
        else if (async_ready_in || sync_ready_in)
            age_reg <= 4'h0;
        else if (age_reg != 4'hf)
            age_reg <= age_reg + 4'h1;
    a_ready_ends: assert property (done_reg && !cs_cfg.upper_no_ready
        && !cs_cfg.lower_no_ready |-> age_reg < 4'hc)
        else $error("cycle ended without ready");
    a_queue_code: assert property (queue_mode_reg && $past(queue_mode_reg)
        |-> {write_strobe_n_reg, addr_latch_reg} == $past(queue_op))
        else $error("queue code wrong");
    a_latch_pulse: assert property (addr_latch_reg && !queue_mode_reg
        |-> read_strobe_n_reg && write_strobe_n_reg ##1 !addr_latch_reg)
        else $error("latch pulse wrong");
    a_write_dir: assert property (!write_strobe_n_reg && !queue_mode_reg
        |-> transceiver_direction_reg)
        else $error("write direction wrong");
    a_read_dir: assert property (!read_strobe_n_reg && !queue_mode_reg
        |-> !transceiver_direction_reg)
        else $error("read direction wrong");
    a_lock_no_grant: assert property (!lock_n_reg |-> !hold_grant_reg)
        else $error("grant during lock");
    a_grant_floats: assert property (hold_grant_reg
        |-> !ctrl_oe_reg && !lock_oe_reg && transceiver_enable_n_reg)
        else $error("driving while granted");
    a_upper_default: assert property (!upper_memory_select_n_reg
        && !cs_cfg.upper_prog |-> addr_reg >= UPPER_DEF_LO)
        else $error("upper select outside default");
    a_lower_off: assert property (!cs_cfg.lower_prog
        |-> lower_memory_select_n_reg)
        else $error("lower select while unprogrammed");
    c_done: cover property (done_reg);
    c_grant: cover property ($rose(hold_grant_reg));
    c_queue: cover property (queue_mode_reg && queue_op == 2'h3);
endmodule : lbcc_local_bus_monitor

bind lbcc_local_bus lbcc_local_bus_monitor mon_u (.*);

// ==== lbcc_far_side.sv ====
// lbcc_far_side: memory or io device answering strobes with ready.
// assumes active-low strobes; ready changes on the falling edge.
module lbcc_far_side
(
    input wire logic ref_clk,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [3:0] wait_cycles,
    input wire logic use_sync,
    input wire logic mute,
    output logic async_ready_in,
    output logic sync_ready_in
);
    logic [3:0] count_reg;
    // wait states counted while a strobe is low
    always_ff @(negedge ref_clk)
        if (read_strobe_n && write_strobe_n)
            count_reg <= 4'h0;
        else if (count_reg != 4'hf)
            count_reg <= count_reg + 4'h1;
    // mute models a slave that never answers, legal only if ignored
    assign async_ready_in = !mute && !use_sync && count_reg > wait_cycles;
    assign sync_ready_in = !mute && use_sync && count_reg > wait_cycles;
endmodule : lbcc_far_side

// ==== lbcc_local_bus_tb.sv ====
// lbcc_local_bus_tb: directed scenarios for the local bus control.
// assumes the far-side model and a bound port monitor.
module lbcc_local_bus_tb
    import lbcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic boundary = 1'b1;
    logic hold_req = 1'b0;
    logic hold_arm = 1'b0;
    logic read_strobe_in = 1'b1;
    logic upper_select_in = 1'b1;
    logic lower_select_in = 1'b1;
    lbcc_req_t req = '0;
    lbcc_cs_cfg_t cs_cfg = '0;
    logic [1:0] queue_op = 2'h0;
    logic [3:0] p_wait = 4'h2;
    logic p_sync = 1'b0;
    logic p_mute = 1'b0;
    logic [6:0] seen;
    logic [1:0] lane;
    int fail_count = 0;
    int samples_checked = 0;
    logic async_ready_in, sync_ready_in, done_reg, queue_mode_reg;
    logic test_mode_reg, read_strobe_n_reg, write_strobe_n_reg;
    logic addr_latch_reg, transceiver_enable_n_reg, lock_n_reg;
    logic transceiver_direction_reg, lock_oe_reg, ctrl_oe_reg;
    logic hold_grant_reg, upper_memory_select_n_reg;
    logic lower_memory_select_n_reg, high_byte_enable_n_reg;
    logic refresh_indicator_n_reg;
    logic [19:0] addr_reg;

    lbcc_local_bus dut_u (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .req_valid(req_valid),
        .req(req),
        .boundary(boundary),
        .queue_op(queue_op),
        .cs_cfg(cs_cfg),
        .async_ready_in(async_ready_in),
        .sync_ready_in(sync_ready_in),
        .hold_req(hold_req),
        .read_strobe_in(read_strobe_in),
        .upper_select_in(upper_select_in),
        .lower_select_in(lower_select_in),
        .done_reg(done_reg),
        .queue_mode_reg(queue_mode_reg),
        .test_mode_reg(test_mode_reg),
        .addr_reg(addr_reg),
        .read_strobe_n_reg(read_strobe_n_reg),
        .write_strobe_n_reg(write_strobe_n_reg),
        .addr_latch_reg(addr_latch_reg),
        .transceiver_enable_n_reg(transceiver_enable_n_reg),
        .transceiver_direction_reg(transceiver_direction_reg),
        .lock_n_reg(lock_n_reg),
        .lock_oe_reg(lock_oe_reg),
        .ctrl_oe_reg(ctrl_oe_reg),
        .hold_grant_reg(hold_grant_reg),
        .upper_memory_select_n_reg(upper_memory_select_n_reg),
        .lower_memory_select_n_reg(lower_memory_select_n_reg),
        .high_byte_enable_n_reg(high_byte_enable_n_reg),
        .refresh_indicator_n_reg(refresh_indicator_n_reg)
    );
    lbcc_far_side far_u (.ref_clk(ref_clk),
        .read_strobe_n(read_strobe_n_reg), .write_strobe_n(write_strobe_n_reg),
        .wait_cycles(p_wait), .use_sync(p_sync), .mute(p_mute),
        .async_ready_in(async_ready_in), .sync_ready_in(sync_ready_in));

    always #20 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic till(ref logic s, input logic v);
        int n;
        for (n = 0; n < 60 && s !== v; n++)
            #40;
        if (n == 60)
        begin
            fail_count++;
            tally_and_finish();
        end
    endtask : till
    // straps are held past the first edge after release, where they count
    task automatic rst(input logic [2:0] straps);
        @(negedge ref_clk);
        reset_n = 1'b0;
        cs_cfg = '0;
        {read_strobe_in, upper_select_in, lower_select_in} = straps;
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        {read_strobe_in, upper_select_in, lower_select_in} = 3'h7;
    endtask : rst
    function automatic lbcc_req_t mk(logic [19:0] a, logic [4:0] f);
        return {a, f};
    endfunction : mk
    // one whole cycle; gathers what the pins did until done
    task automatic cyc(input lbcc_req_t r);
        @(negedge ref_clk);
        seen = '0;
        req = r;
        req_valid = 1'b1;
        // an armed hold rises a clock later, pin_float_test_mode the cycle has started
        @(negedge ref_clk);
        hold_req = hold_arm;
        for (int n = 0; done_reg !== 1'b1; n++)
        begin
            @(posedge ref_clk);
            #1;
            seen = seen | {~read_strobe_n_reg, ~write_strobe_n_reg,
                ~upper_memory_select_n_reg, ~lower_memory_select_n_reg,
                ~lock_n_reg, ~transceiver_enable_n_reg,
                transceiver_direction_reg & ~transceiver_enable_n_reg};
            if (addr_latch_reg === 1'b1)
                lane = {addr_reg[0], high_byte_enable_n_reg};
            if (n == 60)
            begin
                fail_count++;
                tally_and_finish();
            end
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
    endtask : cyc

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_queue;
        chk(queue_mode_reg, 1'h1);
        for (int q = 0; q < 4; q++)
        begin
            @(negedge ref_clk);
            queue_op = q[1:0];
            @(posedge ref_clk);
            #1 chk({write_strobe_n_reg, addr_latch_reg}, q);
        end
    endtask : t_queue
    task automatic t_rw;
        cyc(mk(20'hffc10, 5'h00));
        chk(seen, 7'h52);
        chk(lane, 2'h0);
        p_sync = 1'b1;
        cyc(mk(20'hffc11, 5'h12));
        chk(seen, 7'h33);
        chk(lane, 2'h2);
    endtask : t_rw
    task automatic t_windows;
        cs_cfg = {1'b1, 20'h00400, 20'h004ff, 1'b1, 1'b1, 20'h00000,
            20'h0ffff, 1'b0};
        p_mute = 1'b1;
        cyc(mk(20'h00402, 5'h08));
        chk(seen, 7'h52);
        p_mute = 1'b0;
        cs_cfg.upper_no_ready = 1'b0;
        cyc(mk(20'h00010, 5'h02));
        chk(seen, 7'h4a);
        chk(lane, 2'h1);
        cyc(mk(20'h00010, 5'h08));
        chk(seen, 7'h42);
        cyc(mk(20'h20000, 5'h04));
        chk(lane, 2'h3);
        chk(refresh_indicator_n_reg, 1'h1);
    endtask : t_windows
    // a request while the bus is given away must wait for its return
    task automatic t_hold;
        @(negedge ref_clk);
        boundary = 1'b0;
        hold_req = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(hold_grant_reg, 1'h0);
        boundary = 1'b1;
        till(hold_grant_reg, 1'b1);
        chk(ctrl_oe_reg, 1'h0);
        @(negedge ref_clk);
        req = mk(20'hffc20, 5'h00);
        req_valid = 1'b1;
        repeat (5) @(negedge ref_clk);
        chk(read_strobe_n_reg, 1'h1);
        hold_req = 1'b0;
        till(done_reg, 1'b1);
        // drop the request inside the done cycle so it is not taken twice
        req_valid = 1'b0;
        chk(hold_grant_reg, 1'h0);
    endtask : t_hold
    // a hold raised inside a locked cycle waits for the cycle to end
    task automatic t_lock;
        cs_cfg = '0;
        hold_arm = 1'b1;
        cyc(mk(20'hffc00, 5'h11));
        chk(seen, 7'h37);
        chk(hold_grant_reg, 1'h0);
        till(hold_grant_reg, 1'b1);
        hold_req = 1'b0;
        hold_arm = 1'b0;
        till(hold_grant_reg, 1'b0);
    endtask : t_lock

    initial
    begin
        rst(3'h4);
        chk({test_mode_reg, queue_mode_reg}, 2'h2);
        rst(3'h3);
        t_queue();
        rst(3'h7);
        chk({test_mode_reg, queue_mode_reg}, 2'h0);
        t_rw();
        t_windows();
        t_hold();
        t_lock();
        tally_and_finish();
    end
endmodule : lbcc_local_bus_tb
